// ---- hdl/pllmx_regs.sv ----
`timescale 1ns/1ps

module pllmx_regs
  import pllmx_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port from serial control logic
  input wire logic [pllmx_pkg::REG_AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [pllmx_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [pllmx_pkg::REG_DW-1:0] reg_rdata,
  // Serial read cycle state
  input wire logic read_cycle_active,
  input wire logic read_data_bit,
  // Band search results
  input wire logic vco_band_search_busy,
  input wire logic vco_band_search_done,
  input wire logic [pllmx_pkg::BAND_W-1:0] vco_band_search_result,
  // Lock status
  input wire logic lock_detect,
  // Internal sources for the output pin, indexed by selector code
  input wire logic [31:0] pin_sources,
  // Exact frequency control to the modulator
  output logic exact_freq_en,
  output logic [pllmx_pkg::CHAN_COUNT_W-1:0] exact_freq_ratio,
  // Driver trim
  output logic pfet_disable,
  output logic nfet_disable,
  // Lock indication
  output logic lock_ind,
  // Shared lock / serial out pin
  output logic lock_serial_out_pin_o,
  output logic lock_serial_out_pin_oe_n
);
  import pllmx_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [CHAN_COUNT_W-1:0] chan_count_q;
  logic [PIN_CTRL_W-1:0] pin_ctrl_q;
  logic [BAND_W-1:0] band_q;
  logic busy_q;
  logic lock_q;
  logic [REG_DW-1:0] rdata_q;
  logic pin_q;
  logic oe_n_q;
  logic sel_bit;
  logic [SEL_W-1:0] sel_code;
  logic pin_d;
  logic [REG_DW-1:0] rdata_d;

  function automatic logic wr_hit(input logic wr,
                                  input logic [REG_AW-1:0] a,
                                  input logic [REG_AW-1:0] ofs);
    wr_hit = wr && (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chan_count_q <= CHAN_COUNT_RST;
    end else if (wr_hit(reg_wr, reg_addr, EXACT_FREQ_CHANNEL_COUNT_OFS)) begin
      chan_count_q <= reg_wdata[CHAN_COUNT_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_ctrl_q <= PIN_CTRL_RST;
    end else if (wr_hit(reg_wr, reg_addr, OUTPUT_PIN_SELECT_CTRL_OFS)) begin
      pin_ctrl_q <= reg_wdata[PIN_CTRL_W-1:0];
    end
  end

  // Ratio is passed whole; software keeps it an integer ratio
  assign exact_freq_en = (chan_count_q >= CHAN_COUNT_MIN_ON);
  assign exact_freq_ratio = chan_count_q;
  assign pfet_disable = pin_ctrl_q[PFET_OFF_BIT];
  assign nfet_disable = pin_ctrl_q[NFET_OFF_BIT];

  // ----------------------------------------------------------------
  // Band search readback
  // ----------------------------------------------------------------
  // Only a finished search loads the band; register writes never do
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      band_q <= BAND_RST;
    end else if (vco_band_search_done) begin
      band_q <= vco_band_search_result;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= vco_band_search_busy;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= lock_detect;
    end
  end
  assign lock_ind = lock_q;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    case (reg_addr)
      EXACT_FREQ_CHANNEL_COUNT_OFS: begin
        rdata_d[CHAN_COUNT_W-1:0] = chan_count_q;
      end
      OUTPUT_PIN_SELECT_CTRL_OFS: begin
        rdata_d[PIN_CTRL_W-1:0] = pin_ctrl_q;
      end
      VCO_BAND_READBACK_OFS: begin
        rdata_d[BAND_W-1:0] = band_q;
        rdata_d[BUSY_BIT] = busy_q;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Output source selection
  // ----------------------------------------------------------------
  assign sel_code = pin_ctrl_q[SEL_LSB +: SEL_W];

  always_comb begin
    sel_bit = 1'b0;
    case (pllmx_src_t'(sel_code))
      PLLMX_SRC_TEST_DATA: sel_bit = pin_ctrl_q[TEST_DATA_BIT];
      PLLMX_SRC_LOCK_OUT: sel_bit = lock_q;
      PLLMX_SRC_RSVD7: sel_bit = 1'b0;
      PLLMX_SRC_UNUSED26,
      PLLMX_SRC_UNUSED27,
      PLLMX_SRC_UNUSED28,
      PLLMX_SRC_UNUSED29: sel_bit = 1'b0;
      // Codes 2-6, 8-25, 30, 31 pass the source of the same index
      default: sel_bit = pin_sources[sel_code];
    endcase
  end

  // ----------------------------------------------------------------
  // Shared pin driver
  // ----------------------------------------------------------------
  always_comb begin
    if (pin_ctrl_q[NO_AUTOMUX_BIT] || !read_cycle_active) begin
      pin_d = sel_bit;
    end else begin
      pin_d = read_data_bit;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= !(pin_ctrl_q[DRIVER_ON_BIT] || read_cycle_active);
    end
  end

  assign lock_serial_out_pin_o = pin_q;
  assign lock_serial_out_pin_oe_n = oe_n_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_exact_en;
    @(posedge mclk) disable iff (!rst_n)
      exact_freq_en == (chan_count_q > 14'h0001);
  endproperty
  a_exact_en: assert property (p_exact_en)
    else $error("exact mode enable does not follow channel count");

  property p_count_write;
    @(posedge mclk) disable iff (!rst_n)
      (reg_wr && reg_addr == EXACT_FREQ_CHANNEL_COUNT_OFS)
      |=> exact_freq_ratio == $past(reg_wdata[13:0]);
  endproperty
  a_count_write: assert property (p_count_write)
    else $error("channel count write not applied");

  property p_test_data;
    @(posedge mclk) disable iff (!rst_n)
      (pin_ctrl_q[4:0] == 5'h00 && pin_ctrl_q[6])
      |=> lock_serial_out_pin_o == $past(pin_ctrl_q[5]);
  endproperty
  a_test_data: assert property (p_test_data)
    else $error("code zero does not drive test data bit");

  property p_lock_route;
    @(posedge mclk) disable iff (!rst_n)
      (pin_ctrl_q[4:0] == 5'h01 && pin_ctrl_q[6]) ##1
      (pin_ctrl_q[4:0] == 5'h01 && pin_ctrl_q[6])
      |=> lock_serial_out_pin_o == $past(lock_detect, 2);
  endproperty
  a_lock_route: assert property (p_lock_route)
    else $error("lock indication not routed on code one");

  property p_unused_zero;
    @(posedge mclk) disable iff (!rst_n)
      ((pin_ctrl_q[4:0] == 5'h07 ||
        (pin_ctrl_q[4:0] >= 5'h1A && pin_ctrl_q[4:0] <= 5'h1D)) &&
       pin_ctrl_q[6]) |=> !lock_serial_out_pin_o;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("reserved or unused code drives the pin");

  property p_src_route;
    @(posedge mclk) disable iff (!rst_n)
      (pin_ctrl_q[6] && pin_ctrl_q[4:0] >= 5'h08 &&
       pin_ctrl_q[4:0] <= 5'h19)
      |=> lock_serial_out_pin_o == $past(pin_sources[pin_ctrl_q[4:0]]);
  endproperty
  a_src_route: assert property (p_src_route)
    else $error("selected source not on pin");

  property p_automux;
    @(posedge mclk) disable iff (!rst_n)
      (!pin_ctrl_q[6] && read_cycle_active)
      |=> lock_serial_out_pin_o == $past(read_data_bit);
  endproperty
  a_automux: assert property (p_automux)
    else $error("automux does not carry read data");

  property p_driver;
    @(posedge mclk) disable iff (!rst_n)
      (!pin_ctrl_q[7] && !read_cycle_active) |=> lock_serial_out_pin_oe_n;
  endproperty
  a_driver: assert property (p_driver)
    else $error("pin driven outside read cycle");

  property p_driver_on;
    @(posedge mclk) disable iff (!rst_n)
      pin_ctrl_q[7] |=> !lock_serial_out_pin_oe_n;
  endproperty
  a_driver_on: assert property (p_driver_on)
    else $error("pin driver off while always-on set");

  property p_driver_read;
    @(posedge mclk) disable iff (!rst_n)
      read_cycle_active |=> !lock_serial_out_pin_oe_n;
  endproperty
  a_driver_read: assert property (p_driver_read)
    else $error("pin driver off during read cycle");

  property p_band_hold;
    @(posedge mclk) disable iff (!rst_n)
      !vco_band_search_done |=> $stable(band_q);
  endproperty
  a_band_hold: assert property (p_band_hold)
    else $error("band field changed without search result");

  property p_band_load;
    @(posedge mclk) disable iff (!rst_n)
      vco_band_search_done |=> band_q == $past(vco_band_search_result);
  endproperty
  a_band_load: assert property (p_band_load)
    else $error("band field did not take search result");

  property p_busy_read;
    @(posedge mclk) disable iff (!rst_n)
      (reg_rd && reg_addr == VCO_BAND_READBACK_OFS)
      |=> reg_rdata[8] == $past(busy_q) && reg_rdata[23:9] == 15'h0000;
  endproperty
  a_busy_read: assert property (p_busy_read)
    else $error("busy bit readback wrong");

  property p_busy_track;
    @(posedge mclk) disable iff (!rst_n)
      vco_band_search_busy |=> busy_q;
  endproperty
  a_busy_track: assert property (p_busy_track)
    else $error("busy flag not set during search");

  property p_busy_clear;
    @(posedge mclk) disable iff (!rst_n)
      !vco_band_search_busy |=> !busy_q;
  endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("busy flag set while no search runs");

  property p_ro_write;
    @(posedge mclk) disable iff (!rst_n)
      (reg_wr && reg_addr == VCO_BAND_READBACK_OFS &&
       !vco_band_search_done) |=> $stable(band_q);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write changed read-only band field");

  property p_lock_ind;
    @(posedge mclk) disable iff (!rst_n)
      lock_detect |=> lock_ind;
  endproperty
  a_lock_ind: assert property (p_lock_ind)
    else $error("lock indication not reported");

  property p_lock_clear;
    @(posedge mclk) disable iff (!rst_n)
      !lock_detect |=> !lock_ind;
  endproperty
  a_lock_clear: assert property (p_lock_clear)
    else $error("lock indication set while unlocked");

endmodule

// ---- hdl/pllmx_pkg.sv ----
package pllmx_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int REG_AW = 6;
  localparam int REG_DW = 24;
  localparam logic [5:0] EXACT_FREQ_CHANNEL_COUNT_OFS = 6'h0C;
  localparam logic [5:0] OUTPUT_PIN_SELECT_CTRL_OFS = 6'h0F;
  localparam logic [5:0] VCO_BAND_READBACK_OFS = 6'h10;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int CHAN_COUNT_W = 14;
  localparam int SEL_W = 5;
  localparam int SEL_LSB = 0;
  localparam int TEST_DATA_BIT = 5;
  localparam int NO_AUTOMUX_BIT = 6;
  localparam int DRIVER_ON_BIT = 7;
  localparam int PFET_OFF_BIT = 8;
  localparam int NFET_OFF_BIT = 9;
  localparam int PIN_CTRL_W = 10;
  localparam int BAND_W = 8;
  localparam int BUSY_BIT = 8;

  // ----------------------------------------------------------------
  // Reset values and exact mode enable threshold
  // ----------------------------------------------------------------
  localparam logic [13:0] CHAN_COUNT_RST = 14'h0000;
  localparam logic [9:0] PIN_CTRL_RST = 10'h001;
  localparam logic [7:0] BAND_RST = 8'h20;
  localparam logic [13:0] CHAN_COUNT_MIN_ON = 14'h0002;

  // ----------------------------------------------------------------
  // Output source selector codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    PLLMX_SRC_TEST_DATA = 5'h00,
    PLLMX_SRC_LOCK_OUT = 5'h01,
    PLLMX_SRC_LOCK_TRIG = 5'h02,
    PLLMX_SRC_LOCK_WIN = 5'h03,
    PLLMX_SRC_RING_OSC = 5'h04,
    PLLMX_SRC_SLIP_UP = 5'h05,
    PLLMX_SRC_SLIP_DN = 5'h06,
    PLLMX_SRC_RSVD7 = 5'h07,
    PLLMX_SRC_REF_BUF = 5'h08,
    PLLMX_SRC_REF_DIV = 5'h09,
    PLLMX_SRC_VCO_DIV = 5'h0A,
    PLLMX_SRC_MOD_CLK = 5'h0B,
    PLLMX_SRC_AUX_CLK = 5'h0C,
    PLLMX_SRC_AUX_SCLK = 5'h0D,
    PLLMX_SRC_AUX_EN = 5'h0E,
    PLLMX_SRC_AUX_DOUT = 5'h0F,
    PLLMX_SRC_PC_DN = 5'h10,
    PLLMX_SRC_PC_UP = 5'h11,
    PLLMX_SRC_SDM_DLY = 5'h12,
    PLLMX_SRC_SDM_CORE = 5'h13,
    PLLMX_SRC_INT_WR = 5'h14,
    PLLMX_SRC_FRAC_WR = 5'h15,
    PLLMX_SRC_AUX_WR = 5'h16,
    PLLMX_SRC_LATCH_EN = 5'h17,
    PLLMX_SRC_DIV_SYNC = 5'h18,
    PLLMX_SRC_SEED_LD = 5'h19,
    PLLMX_SRC_UNUSED26 = 5'h1A,
    PLLMX_SRC_UNUSED27 = 5'h1B,
    PLLMX_SRC_UNUSED28 = 5'h1C,
    PLLMX_SRC_UNUSED29 = 5'h1D,
    PLLMX_SRC_SOUT_EN = 5'h1E,
    PLLMX_SRC_SOFT_RST = 5'h1F
  } pllmx_src_t;

endpackage

// ---- verif/pllmx_host_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Serial read cycle seen from the host side
// ----------------------------------------------------------------
module pllmx_host_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bench control
  input wire logic rd_go,
  input wire logic rd_bit,
  // Read cycle state toward the block
  output logic read_cycle_active,
  output logic read_data_bit
);
  logic active_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
    end else begin
      active_q <= rd_go;
    end
  end

  assign read_cycle_active = active_q;
  // Outside a read cycle the data line shows the inverse, not a held value
  assign read_data_bit = active_q ? rd_bit : ~rd_bit;
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps

module testbench;
  import pllmx_pkg::*;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic reg_wr = 1'b0;
  logic [23:0] reg_wdata = 24'h000000;
  logic reg_rd = 1'b0;
  logic [23:0] reg_rdata;
  logic read_cycle_active;
  logic read_data_bit;
  logic rd_go = 1'b0;
  logic rd_bit = 1'b0;
  logic busy = 1'b0;
  logic done = 1'b0;
  logic [7:0] result = 8'h00;
  logic lock_detect = 1'b0;
  logic [31:0] pin_sources = 32'h00000000;
  logic exact_freq_en;
  logic [13:0] exact_freq_ratio;
  logic pfet_disable;
  logic nfet_disable;
  logic lock_ind;
  logic pin_o;
  logic pin_oe_n;
  int fail_count = 0;
  int checked = 0;
  logic [13:0] cc [4] = '{14'h0000, 14'h0001, 14'h0002, 14'h3FFF};

  initial begin
    forever #10 mclk = ~mclk;
  end

  pllmx_regs pllmx_regs_inst (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .read_cycle_active(read_cycle_active), .read_data_bit(read_data_bit),
    .vco_band_search_busy(busy), .vco_band_search_done(done),
    .vco_band_search_result(result), .lock_detect(lock_detect),
    .pin_sources(pin_sources), .exact_freq_en(exact_freq_en),
    .exact_freq_ratio(exact_freq_ratio), .pfet_disable(pfet_disable),
    .nfet_disable(nfet_disable), .lock_ind(lock_ind),
    .lock_serial_out_pin_o(pin_o), .lock_serial_out_pin_oe_n(pin_oe_n)
  );

  pllmx_host_model pllmx_host_model_inst (
    .mclk(mclk), .rst_n(rst_n), .rd_go(rd_go), .rd_bit(rd_bit),
    .read_cycle_active(read_cycle_active), .read_data_bit(read_data_bit)
  );

  task automatic print_verdict();
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [23:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, exp);
  endtask

  task automatic pin_chk(input logic p, input logic oe);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk(24'(pin_o), 24'(p));
    chk(24'(pin_oe_n), 24'(oe));
  endtask

  // Reserved code 7 and unused codes 26-29 read 0; others follow the stimulus level
  function automatic logic exp_pin(input int c, input logic v);
    if (c == 7 || (c >= 26 && c <= 29)) begin
      return 1'b0;
    end
    return v;
  endfunction

  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rd(6'h0C, 24'h000000);
    rd(6'h0F, 24'h000001);
    rd(6'h10, 24'h000020);
    for (int i = 0; i < 4; i++) begin
      wr(6'h0C, {10'h000, cc[i]});
      @(negedge mclk);
      chk(24'(exact_freq_en), 24'(cc[i] >= 14'h0002));
      chk(24'(exact_freq_ratio), 24'(cc[i]));
    end
    wr(6'h0C, 24'hFFFFFF);
    rd(6'h0C, 24'h003FFF);
    wr(6'h0F, 24'hFFFD00);
    rd(6'h0F, 24'h000100);
    chk(24'({pfet_disable, nfet_disable}), 24'h000002);
    wr(6'h01, 24'hFFFFFF);
    rd(6'h01, 24'h000000);
    // Band search running, then two results
    @(posedge mclk);
    busy <= 1'b1;
    rd(6'h10, 24'h000120);
    @(posedge mclk);
    done <= 1'b1;
    result <= 8'h11;
    @(posedge mclk);
    done <= 1'b0;
    busy <= 1'b0;
    rd(6'h10, 24'h000011);
    wr(6'h10, 24'hFFFFFF);
    rd(6'h10, 24'h000011);
    @(posedge mclk);
    done <= 1'b1;
    result <= 8'h00;
    @(posedge mclk);
    done <= 1'b0;
    rd(6'h10, 24'h000000);
    // Every selector code, pin driven always and without automux
    for (int v = 0; v < 2; v++) begin
      for (int c = 0; c < 32; c++) begin
        @(posedge mclk);
        pin_sources <= (v[0] ^ (c < 2)) ? (32'h1 << c) : ~(32'h1 << c);
        lock_detect <= v[0];
        wr(6'h0F, 24'h0000C0 | (24'(v) << 5) | 24'(c));
        pin_chk(exp_pin(c, v[0]), 1'b0);
        chk(24'(lock_ind), 24'(v[0]));
      end
    end
    // Automux between read data and the selected source
    @(posedge mclk);
    pin_sources <= 32'hFFFFFFFF;
    wr(6'h0F, 24'h000004);
    pin_chk(1'b1, 1'b1);
    @(posedge mclk);
    rd_go <= 1'b1;
    rd_bit <= 1'b0;
    pin_chk(1'b0, 1'b0);
    wr(6'h0F, 24'h000044);
    pin_chk(1'b1, 1'b0);
    @(posedge mclk);
    rd_go <= 1'b0;
    pin_chk(1'b1, 1'b1);
    print_verdict();
  end
endmodule
